// >>> verilog/rcs_pkg.sv
package rcs_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] TFUNC_OFS = 4'h4;
   localparam logic [3:0] COMM_OFS = 4'h8;
   localparam logic [3:0] STAT_OFS = 4'hC;

   // ==========================================================
   // control register fields
   localparam int SRC_LSB = 0;
   localparam int PREV_LSB = 2;
   localparam int PU_BIT = 4;
   localparam int RST_BIT = 5;
   localparam int KDIR_BIT = 6;
   localparam logic [1:0] SRC_RST = 2'h1;
   localparam logic [1:0] PREV_RST = 2'h0;
   localparam logic PU_RST = 1'b0;
   localparam logic RSTART_RST = 1'b0;
   localparam logic KDIR_RST = 1'b0;

   // ==========================================================
   // run prevention codes
   localparam logic [1:0] PREV_NONE = 2'h0;
   localparam logic [1:0] PREV_FWD = 2'h1;
   localparam logic [1:0] PREV_REV = 2'h2;

   // ==========================================================
   // terminal function codes, 5 bits per terminal
   localparam int FUNC_W = 5;
   localparam logic [4:0] FUNC_FWD_RUN = 5'h00;
   localparam logic [4:0] FUNC_REV_DIR = 5'h01;
   localparam logic [4:0] FUNC_MAX = 5'h1B;
   localparam logic [24:0] TFUNC_RST = {5'h04, 5'h03, 5'h02, 5'h01, 5'h00};

   // ==========================================================
   // serial link settings, kept for the host
   localparam int PROTO_BIT = 8;
   localparam int SPEED_LSB = 9;
   localparam logic [7:0] STATION_RST = 8'h01;
   localparam logic [7:0] STATION_MAX = 8'hFA;
   localparam logic PROTO_RST = 1'b0;
   localparam logic [2:0] SPEED_RST = 3'h3;
   localparam logic [2:0] SPEED_MAX = 3'h4;

   // ==========================================================
   // status register fields
   localparam int ST_RUN = 0;
   localparam int ST_REV = 1;
   localparam int ST_TRIP = 2;
   localparam int ST_HOLD = 3;

   typedef enum logic [1:0] {
      SRC_KEYPAD,
      SRC_TERM_FR,
      SRC_TERM_RD,
      SRC_SERIAL
   } rcs_src_type;
endpackage : rcs_pkg

// >>> verilog/rcs_term_slot.sv
`timescale 1ns/100ps
// ==========================================================
// one input terminal: role decode from its function code
module rcs_term_slot
   import rcs_pkg::*;
(
   input wire logic level_i,
   input wire logic [4:0] func_i,
   output logic fwd_o,
   output logic rev_o
);
   // only the two run roles matter here, other codes stay silent
   assign fwd_o = level_i && (func_i == FUNC_FWD_RUN);
   assign rev_o = level_i && (func_i == FUNC_REV_DIR);
endmodule : rcs_term_slot

// >>> verilog/rcs_ahb_slave.sv
`timescale 1ns/100ps
// ==========================================================
// ahb-lite front end: zero-wait writes, one wait state on reads
module rcs_ahb_slave
   import rcs_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   output logic [3:0] addr_o,
   input wire logic [31:0] rd_data_i,
   output logic wr_en_o,
   output logic [31:0] wr_data_o
);
   logic take;
   logic hit;
   logic wpend_r;
   logic rpend_r;
   logic [3:0] addr_r;
   logic [31:0] hrdata_r;

   // word accesses in the first 16 bytes only; others read zero
   assign take = ce_i && hsel_i && hready_i && htrans_i[1];
   assign hit = (haddr_i[31:4] == 28'h000_0000) && (haddr_i[1:0] == 2'h0)
                && (hsize_i == 3'h2);

   // read waits one cycle so a write just before it is seen
   assign hreadyout_o = ce_i && !rpend_r;
   assign hresp_o = 1'b0;
   assign hrdata_o = hrdata_r;
   assign addr_o = addr_r;
   assign wr_en_o = wpend_r && ce_i;
   assign wr_data_o = hwdata_i;

   // address phase capture
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         wpend_r <= 1'b0;
         rpend_r <= 1'b0;
         addr_r <= 4'h0;
      end else if (ce_i) begin
         wpend_r <= take && hwrite_i && hit;
         rpend_r <= take && !hwrite_i;
         if (take) begin
            addr_r <= hit ? haddr_i[3:0] : 4'h1;
         end
      end
   end

   // read data registered in the wait cycle
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         hrdata_r <= 32'h0000_0000;
      end else if (ce_i && rpend_r) begin
         hrdata_r <= rd_data_i;
      end
   end
endmodule : rcs_ahb_slave

// >>> verilog/rcs_run_select.sv
`timescale 1ns/100ps
// ==========================================================
// run command source selector
// Contract
// [RL1] Source 1: one terminal commands forward, another commands reverse.
// [RL2] Source 1: both terminals on or both off means stop.
// [RL3] Source 2: one terminal is run, another selects direction.
// [RL4] Source 2: run on with direction off runs forward.
// [RL5] Source 2: run on with direction on runs reverse.
// [RL6] Terminal function 0 is forward/run, 1 is reverse/direction; range 0 to 27.
// [RL7] Three assignable terminals in standard variant, five in advanced.
// [RL8] Source 3: run commands come only from the serial link.
// [RL9] Serial source exists only in the advanced variant.
// [RL10] Host sets station 1-250, protocol 0-1, speed 0-4 before serial runs.
// [RL11] Prevention 0 allows both, 1 blocks forward, 2 blocks reverse.
// [RL12] Keypad direction applies only with source 0; always readable and writable.
// [RL13] Power-up run enabled: start at power-up if terminal run asserted; code never does: enable resets to 0, first_r clears before any write.
// [RL14] Power-up run acts on terminal sources 1 and 2.
// [RL15] Restart enabled: resume after trip reset if terminal run still asserted.
// [RL16] Restart starts at once on trip reset from terminal or keypad.
// [RL17] Source 0: keypad run key starts, stop key stops.
// [RL18] Source resets to 1; a blocked direction stops, never reverses.
module rcs_run_select
   import rcs_pkg::*;
#(
   parameter bit ADV_IO = 1'b1
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   input wire logic [4:0] input_terminal_i,
   input wire logic keypad_run_key_i,
   input wire logic keypad_stop_key_i,
   input wire logic serial_run_i,
   input wire logic serial_reverse_i,
   input wire logic fault_trip_i,
   input wire logic trip_reset_term_i,
   input wire logic trip_reset_key_i,
   output logic run_o,
   output logic reverse_o
);
   localparam int NUM_TERM = ADV_IO ? 5 : 3;

   logic [3:0] addr;
   logic [31:0] rd_data;
   logic wr_en;
   logic [31:0] wr_data;
   rcs_src_type src_r;
   logic [1:0] prev_r;
   logic power_up_run_enable_r;
   logic restart_after_reset_enable_r;
   logic keypad_direction_select_r;
   logic [24:0] tfunc_r;
   logic [24:0] tfunc_nxt;
   logic [7:0] station_r;
   logic proto_r;
   logic [2:0] speed_r;
   logic kp_run_r;
   logic tripped_r;
   logic first_r;
   logic hold_r;
   logic run_r;
   logic rev_r;
   logic [4:0] fwd_vec;
   logic [4:0] rev_vec;
   logic forward_run_cmd;
   logic reverse_run_cmd;
   logic term_src;
   logic term_run;
   logic req_run;
   logic req_rev;
   logic blocked;
   logic trip_reset;
   logic trip_clear;
   logic run_nxt;
   logic start_hold;

   // ==========================================================
   // bus front end
   rcs_ahb_slave u_bus (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .hsel_i(hsel_i),
      .haddr_i(haddr_i),
      .htrans_i(htrans_i),
      .hwrite_i(hwrite_i),
      .hsize_i(hsize_i),
      .hwdata_i(hwdata_i),
      .hready_i(hready_i),
      .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o),
      .hrdata_o(hrdata_o),
      .addr_o(addr),
      .rd_data_i(rd_data),
      .wr_en_o(wr_en),
      .wr_data_o(wr_data)
   );

   // read mux; unmapped words read zero
   assign rd_data =
      (addr == CTRL_OFS) ? {25'h000_0000, keypad_direction_select_r,
                            restart_after_reset_enable_r, power_up_run_enable_r,
                            prev_r, src_r} :
      (addr == TFUNC_OFS) ? {7'h00, tfunc_r} :
      (addr == COMM_OFS) ? {20'h0_0000, speed_r, proto_r, station_r} :
      (addr == STAT_OFS) ? {26'h000_0000, src_r, hold_r, tripped_r, rev_r, run_r} :
      32'h0000_0000;

   // ==========================================================
   // terminal role decode, one slot per fitted terminal
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_term
         if (gi < NUM_TERM) begin : g_fit
            rcs_term_slot u_slot ( // [RL7]
               .level_i(input_terminal_i[gi]),
               .func_i(tfunc_r[gi*FUNC_W +: FUNC_W]),
               .fwd_o(fwd_vec[gi]),
               .rev_o(rev_vec[gi])
            );
         end else begin : g_none
            assign fwd_vec[gi] = 1'b0;
            assign rev_vec[gi] = 1'b0;
         end
      end
   endgenerate

   // codes above 27 are refused field by field
   always_comb begin
      tfunc_nxt = tfunc_r;
      for (int i = 0; i < 5; i++) begin
         if (wr_data[i*FUNC_W +: FUNC_W] <= FUNC_MAX) begin // [RL6]
            tfunc_nxt[i*FUNC_W +: FUNC_W] = wr_data[i*FUNC_W +: FUNC_W];
         end
      end
   end

   // ==========================================================
   // command selection
   assign forward_run_cmd = |fwd_vec;
   assign reverse_run_cmd = |rev_vec;
   assign term_src = (src_r == SRC_TERM_FR) || (src_r == SRC_TERM_RD); // [RL14]
   // fwd/rev pair: exactly one on runs, both on or both off stops
   assign term_run = (src_r == SRC_TERM_FR) ? (forward_run_cmd ^ reverse_run_cmd) : // [RL1] [RL2]
                     (src_r == SRC_TERM_RD) ? forward_run_cmd : 1'b0; // [RL3]
   assign req_run = (src_r == SRC_KEYPAD) ? kp_run_r :
                    (src_r == SRC_SERIAL) ? (ADV_IO && serial_run_i) : term_run; // [RL8] [RL9]
   assign req_rev = (src_r == SRC_KEYPAD) ? keypad_direction_select_r : // [RL12]
                    (src_r == SRC_SERIAL) ? serial_reverse_i :
                    reverse_run_cmd; // [RL4] [RL5]
   // a blocked direction stops the motor rather than turning it round
   assign blocked = ((prev_r == PREV_FWD) && !req_rev) ||
                    ((prev_r == PREV_REV) && req_rev); // [RL11] [RL18]
   assign trip_reset = trip_reset_term_i || trip_reset_key_i; // [RL16]
   assign trip_clear = tripped_r && trip_reset && !fault_trip_i;
   // hold-off must bite in the cycle it arises, not one edge later
   assign start_hold = term_src && (hold_r || (first_r && !power_up_run_enable_r)); // [RL13]
   assign run_nxt = req_run && !blocked && !tripped_r && !fault_trip_i && !start_hold;

   // ==========================================================
   // settings written by software
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         src_r <= rcs_src_type'(SRC_RST); // [RL18]
         prev_r <= PREV_RST;
         power_up_run_enable_r <= PU_RST;
         restart_after_reset_enable_r <= RSTART_RST;
         keypad_direction_select_r <= KDIR_RST;
         tfunc_r <= TFUNC_RST;
         station_r <= STATION_RST;
         proto_r <= PROTO_RST;
         speed_r <= SPEED_RST;
      end else if (ce_i && wr_en) begin
         if (addr == CTRL_OFS) begin
            src_r <= rcs_src_type'(wr_data[SRC_LSB +: 2]);
            if (wr_data[PREV_LSB +: 2] != 2'h3) begin
               prev_r <= wr_data[PREV_LSB +: 2];
            end
            power_up_run_enable_r <= wr_data[PU_BIT];
            restart_after_reset_enable_r <= wr_data[RST_BIT];
            keypad_direction_select_r <= wr_data[KDIR_BIT];
         end
         if (addr == TFUNC_OFS) begin
            tfunc_r <= tfunc_nxt;
         end
         // out-of-range link settings are refused, held for the host
         if (addr == COMM_OFS) begin // [RL10]
            if (wr_data[7:0] != 8'h00 && wr_data[7:0] <= STATION_MAX) begin
               station_r <= wr_data[7:0];
            end
            proto_r <= wr_data[PROTO_BIT];
            if (wr_data[SPEED_LSB +: 3] <= SPEED_MAX) begin
               speed_r <= wr_data[SPEED_LSB +: 3];
            end
         end
      end
   end

   // ==========================================================
   // run state: keypad latch, trip, start hold-off, outputs
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         kp_run_r <= 1'b0;
         tripped_r <= 1'b0;
         first_r <= 1'b1;
         hold_r <= 1'b0;
         run_r <= 1'b0;
         rev_r <= 1'b0;
      end else if (ce_i) begin
         // stop key wins over a run key pressed together
         kp_run_r <= (src_r == SRC_KEYPAD) && !keypad_stop_key_i && !fault_trip_i &&
                     (kp_run_r || keypad_run_key_i); // [RL17]
         tripped_r <= fault_trip_i || (tripped_r && !trip_reset);
         first_r <= 1'b0;
         // a held terminal run needs a fresh edge unless enabled to carry over
         hold_r <= term_run && (hold_r || (first_r && !power_up_run_enable_r) ||
                   (trip_clear && !restart_after_reset_enable_r)); // [RL13] [RL15]
         run_r <= run_nxt;
         rev_r <= run_nxt && req_rev;
      end
   end

   assign run_o = run_r;
   assign reverse_o = rev_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_tripped_held;
      ce_i && tripped_r && !fault_trip_i && term_run && !blocked;
   endsequence
   sequence s_reset_applied;
      trip_reset && restart_after_reset_enable_r && !hold_r;
   endsequence

   AST_FR_STOP: assert property ( // [RL2]
      ce_i && src_r == SRC_TERM_FR && (forward_run_cmd == reverse_run_cmd) |=> !run_r)
      else $error("fwd/rev pair equal did not stop");
   AST_RD_FWD: assert property ( // [RL4]
      ce_i && src_r == SRC_TERM_RD && forward_run_cmd && !reverse_run_cmd && !tripped_r
      && !fault_trip_i && !hold_r && prev_r != PREV_FWD |=> run_r && !rev_r)
      else $error("run terminal did not run forward");
   AST_RD_REV: assert property ( // [RL5]
      ce_i && src_r == SRC_TERM_RD && forward_run_cmd && reverse_run_cmd && !tripped_r
      && !fault_trip_i && !hold_r && prev_r != PREV_REV |=> run_r && rev_r)
      else $error("direction terminal did not reverse");
   AST_SERIAL_ONLY: assert property ( // [RL8]
      ce_i && src_r == SRC_SERIAL && !serial_run_i |=> !run_r)
      else $error("serial source ran without serial run");
   AST_NO_SERIAL_STD: assert property ( // [RL9]
      ce_i && !ADV_IO && src_r == SRC_SERIAL |=> !run_r)
      else $error("standard variant ran from serial");
   AST_PREVENT: assert property ( // [RL11]
      ce_i && prev_r == PREV_FWD |=> !(run_r && !rev_r))
      else $error("forward run while prevented");
   AST_KEYPAD_DIR: assert property ( // [RL12]
      ce_i && src_r == SRC_KEYPAD && run_nxt |=> rev_r == $past(keypad_direction_select_r))
      else $error("keypad direction not applied");
   AST_STOP_KEY: assert property ( // [RL17]
      ce_i && src_r == SRC_KEYPAD && keypad_stop_key_i ##1 ce_i |=> !run_r)
      else $error("stop key did not stop");
   AST_RESTART: assert property ( // [RL16]
      s_tripped_held ##0 s_reset_applied ##1 (ce_i && !fault_trip_i && term_run && !blocked)
      |=> run_r)
      else $error("no restart after trip reset");
   AST_HOLD_OFF: assert property ( // [RL15]
      ce_i && trip_clear && term_src && term_run && !restart_after_reset_enable_r
      |=> !run_r [*2])
      else $error("restarted while restart disabled");
   AST_SRC_RESET: assert property ( // [RL18]
      $rose(reset_n_i) |-> src_r == SRC_TERM_FR)
      else $error("source not 1 after reset");

   // inputs are sampled one edge before the registered outputs answer
   AST_FR_RUN: assert property ( // [RL1]
      ce_i && src_r == SRC_TERM_FR && (forward_run_cmd != reverse_run_cmd) && !blocked
      && !tripped_r && !fault_trip_i && !hold_r && !first_r
      |=> run_r && (rev_r == $past(reverse_run_cmd)))
      else $error("single fwd/rev terminal did not run");
   AST_PU_HOLD: assert property ( // [RL13]
      ce_i && first_r && term_src && !power_up_run_enable_r |=> !run_r)
      else $error("ran at power-up while disabled");
   AST_PREVENT_REV: assert property ( // [RL11]
      ce_i && prev_r == PREV_REV |=> !rev_r)
      else $error("reverse run while prevented");
   AST_TRIP_STOP: assert property ( // [RL15]
      ce_i && (fault_trip_i || tripped_r) |=> !run_r)
      else $error("ran while tripped");
   AST_KEYPAD_IDLE: assert property ( // [RL17]
      ce_i && src_r == SRC_KEYPAD && !kp_run_r |=> !run_r)
      else $error("keypad source ran without run key");
endmodule : rcs_run_select

// >>> testbench/rcs_field_model.sv
`timescale 1ns/100ps
// ==========================================================
// contacts, keypad and serial host in front of the selector
module rcs_field_model
   import rcs_pkg::*;
(
   input wire logic mclk_i,
   input wire logic [8:0] req_i,
   output logic [4:0] terminal_o,
   output logic key_run_o,
   output logic key_stop_o,
   output logic ser_run_o,
   output logic ser_rev_o
);
   // contacts switch on a clock edge, like a synchronised input stage
   always_ff @(posedge mclk_i) begin
      terminal_o <= req_i[4:0];
      key_run_o <= req_i[5];
      key_stop_o <= req_i[6];
      // host only issues serial reverse together with a serial run
      ser_run_o <= req_i[7];
      ser_rev_o <= req_i[8] & req_i[7];
   end
endmodule : rcs_field_model

// >>> testbench/tb.sv
`timescale 1ns/100ps
module tb
   import rcs_pkg::*;
;
   logic mclk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic hrdy, hresp, run_o, reverse_o;
   logic [31:0] hrdata, rd_q;
   logic resp_q;
   logic [8:0] req = 9'h001;
   logic fault = 1'b0;
   logic rst_term = 1'b0;
   logic rst_key = 1'b0;
   logic [4:0] term;
   logic krun, kstop, srun, srev;
   int failures = 0;
   int comparisons = 0;

   initial forever #5 mclk_i = ~mclk_i;

   rcs_field_model rcs_field_model_i (.mclk_i(mclk_i), .req_i(req), .terminal_o(term),
      .key_run_o(krun), .key_stop_o(kstop), .ser_run_o(srun), .ser_rev_o(srev));

   rcs_run_select rcs_run_select_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
      .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
      .hresp_o(hresp), .hrdata_o(hrdata), .input_terminal_i(term),
      .keypad_run_key_i(krun), .keypad_stop_key_i(kstop), .serial_run_i(srun),
      .serial_reverse_i(srev), .fault_trip_i(fault), .trip_reset_term_i(rst_term),
      .trip_reset_key_i(rst_key), .run_o(run_o), .reverse_o(reverse_o));

   // ==========================================================
   // reporting
   task end_of_test;
      $display("checks %0d, mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // ==========================================================
   // ahb-lite master: ready and read data are sampled at the rising edge
   task wait_rdy;
      int n;
      n = 0;
      @(posedge mclk_i);
      while (hrdy !== 1'b1) begin
         n++;
         if (n > 20) begin
            failures++;
            $display("ERROR %0t: bus wait timed out", $time);
            end_of_test();
         end
         @(posedge mclk_i);
      end
      rd_q = hrdata;
      resp_q = hresp;
   endtask : wait_rdy

   task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask : xfer

   task wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task rd_chk(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk(rd_q, exp);
      chk({31'h0000_0000, resp_q}, 32'h0000_0000);
   endtask : rd_chk

   // ==========================================================
   // command side: set requests, let two registers settle, compare
   task cmd(input logic [8:0] r, input logic [1:0] exp);
      req <= r;
      repeat (4) @(negedge mclk_i);
      chk({30'h0, reverse_o, run_o}, {30'h0, exp});
      @(posedge mclk_i);
   endtask : cmd

   task pulse_reset(input logic key);
      if (key) rst_key <= 1'b1;
      else rst_term <= 1'b1;
      @(posedge mclk_i);
      rst_key <= 1'b0;
      rst_term <= 1'b0;
      @(posedge mclk_i);
   endtask : pulse_reset

   // ==========================================================
   // main sequence
   initial begin
      repeat (4) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      @(posedge mclk_i);
      rd_chk({28'h0, CTRL_OFS}, 32'h0000_0001);
      rd_chk({28'h0, TFUNC_OFS}, 32'h0041_8820);
      rd_chk({28'h0, COMM_OFS}, 32'h0000_0601);
      rd_chk(32'h0000_0010, 32'h0000_0000);
      // run held through power-up stays off until it drops once
      cmd(9'h001, 2'b00);
      cmd(9'h000, 2'b00);
      cmd(9'h001, 2'b01);
      cmd(9'h003, 2'b00);
      cmd(9'h002, 2'b11);
      cmd(9'h000, 2'b00);
      wr({28'h0, CTRL_OFS}, 32'h0000_0002);
      cmd(9'h001, 2'b01);
      cmd(9'h003, 2'b11);
      cmd(9'h002, 2'b00);
      cmd(9'h000, 2'b00);
      wr({28'h0, CTRL_OFS}, 32'h0000_0005);
      cmd(9'h001, 2'b00);
      cmd(9'h002, 2'b11);
      cmd(9'h000, 2'b00);
      wr({28'h0, CTRL_OFS}, 32'h0000_0009);
      cmd(9'h002, 2'b00);
      cmd(9'h001, 2'b01);
      cmd(9'h000, 2'b00);
      wr({28'h0, CTRL_OFS}, 32'h0000_000D);
      rd_chk({28'h0, CTRL_OFS}, 32'h0000_0009);
      // roles moved: bit 2 runs, bit 1 reverses, bit 0 unrelated
      wr({28'h0, CTRL_OFS}, 32'h0000_0001);
      wr({28'h0, TFUNC_OFS}, 32'h0041_8025);
      wr({28'h0, TFUNC_OFS}, 32'h0041_803C);
      rd_chk({28'h0, TFUNC_OFS}, 32'h0041_8025);
      cmd(9'h004, 2'b01);
      cmd(9'h000, 2'b00);
      cmd(9'h001, 2'b00);
      cmd(9'h010, 2'b00);
      cmd(9'h000, 2'b00);
      wr({28'h0, TFUNC_OFS}, 32'h0001_8025);
      cmd(9'h010, 2'b01);
      cmd(9'h000, 2'b00);
      wr({28'h0, TFUNC_OFS}, 32'h0041_8820);
      // host sets station 5 before serial runs; speed code 5 is refused
      wr({28'h0, COMM_OFS}, 32'h0000_0A05);
      rd_chk({28'h0, COMM_OFS}, 32'h0000_0605);
      wr({28'h0, CTRL_OFS}, 32'h0000_0003);
      cmd(9'h001, 2'b00);
      cmd(9'h080, 2'b01);
      cmd(9'h180, 2'b11);
      cmd(9'h000, 2'b00);
      wr({28'h0, CTRL_OFS}, 32'h0000_0040);
      cmd(9'h020, 2'b11);
      cmd(9'h000, 2'b11);
      cmd(9'h040, 2'b00);
      cmd(9'h000, 2'b00);
      wr({28'h0, CTRL_OFS}, 32'h0000_0041);
      rd_chk({28'h0, CTRL_OFS}, 32'h0000_0041);
      cmd(9'h001, 2'b01);
      // trip with restart off: run must drop and stay off after reset
      fault <= 1'b1;
      cmd(9'h001, 2'b00);
      fault <= 1'b0;
      pulse_reset(1'b1);
      cmd(9'h001, 2'b00);
      cmd(9'h000, 2'b00);
      cmd(9'h001, 2'b01);
      wr({28'h0, CTRL_OFS}, 32'h0000_0021);
      fault <= 1'b1;
      cmd(9'h001, 2'b00);
      fault <= 1'b0;
      pulse_reset(1'b0);
      cmd(9'h001, 2'b01);
      fault <= 1'b1;
      cmd(9'h001, 2'b00);
      fault <= 1'b0;
      pulse_reset(1'b1);
      cmd(9'h001, 2'b01);
      end_of_test();
   end
endmodule : tb
